// ---- verilog/bft_consts.vh ----
// Purpose: Shared constants of the breaker failure timer.
// Assumes: Included by its bare name from the design files.
// Notes: Delays count in steps of one program cycle.
`ifndef BFT_CONSTS_VH
`define BFT_CONSTS_VH
`define BFT_CLK_HZ 10000000
`define BFT_STEP_US 5000
`define BFT_TICK_CYCLES (`BFT_CLK_HZ / 1000000 * `BFT_STEP_US)
`define BFT_STEP_MS 5
`define BFT_FAIL_DELAY_MS 200
`define BFT_RETRIP_DELAY_MS 100
`define BFT_FAIL_STEPS (`BFT_FAIL_DELAY_MS / `BFT_STEP_MS)
`define BFT_RETRIP_STEPS (`BFT_RETRIP_DELAY_MS / `BFT_STEP_MS)
`define BFT_DELAY_W 20
`define BFT_REG_CONFIG 8'h00
`define BFT_REG_FAIL_DELAY 8'h04
`define BFT_REG_RETRIP_DELAY 8'h08
`define BFT_REG_EVENT_SEL 8'h0C
`define BFT_REG_STATUS 8'h10
`define BFT_REG_TIME_TO_FAIL 8'h14
`define BFT_REG_TIME_TO_RETRIP 8'h18
`define BFT_REG_LOG_STATE 8'h1C
`define BFT_REG_LOG_SEL 8'h20
`define BFT_REG_LOG_STAMP 8'h24
`define BFT_REG_LOG_CURRENT 8'h28
`define BFT_REG_LOG_RETRIP 8'h2C
`define BFT_REG_LOG_FAIL 8'h30
`define BFT_CONFIG_RST 3'h4
`define BFT_EVENT_SEL_RST 16'hFFFF
`define BFT_CRIT_CUR 2'h0
`define BFT_CRIT_CUR_AND_OUT 2'h1
`define BFT_CRIT_CUR_OR_OUT 2'h2
`define BFT_CRIT_INPUT 2'h3
`define BFT_CFG_RETRIP_BIT 2
`define BFT_COND_NORMAL 3'h0
`define BFT_COND_START 3'h1
`define BFT_COND_RETRIP 3'h2
`define BFT_COND_FAIL 3'h3
`define BFT_COND_BLOCKED 3'h4
`define BFT_EV_SOURCES 8
`define BFT_LOG_DEPTH 12
`define BFT_LOG_AW 4
`define BFT_LOG_W 111
`define BFT_LOG_LAST 4'hB
`define BFT_RESP_OKAY 2'h0
`define BFT_RESP_SLVERR 2'h2
`endif

// ---- verilog/bft_log_mem.v ----
// Purpose: Storage for the operation log entries.
// Assumes: One write port and one read port on the same clock.
// Notes: Slots never written read as unknown; software reads written ones.
`timescale 1ns/1ns
module bft_log_mem #(
  parameter W = 111,
  parameter D = 12,
  parameter A = 4
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write side
  input wire we,
  input wire [A-1:0] waddr,
  input wire [W-1:0] wdata,
  // Read side
  input wire [A-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:D-1];

  always @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata <= {W{1'b0}};
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ---- verilog/bft_breaker_failure_timer.v ----
// Purpose: Breaker failure supervision with timers, events and a log.
// Assumes: Comparator and trip inputs are synchronous to aclk.
// Notes: Timers advance once per program cycle of TICK_CYCLES clocks.
// What this block does
// - Current-only: overcurrent starts timer, trip ignored.
// - Current-only: expiry with current high asserts failure.
// - Current-only: timer clears when currents drop.
// - Current-and-output: timer halted until trip active.
// - Current-and-output: run and fail while both hold.
// - Current-and-output: reset when either one drops.
// - Current-or-output: either condition starts counting.
// - Current-or-output: either persisting full delay fails.
// - Current-or-output: reset only when both drop.
// - Dedicated mode: digital input drives the timer.
// - Dedicated mode: own trip output for failure only.
// - ON/OFF events for eight sources, selectable.
// - Events carry time stamp and process data.
// - Rolling log of twelve latest operations.
// - Log entry holds stamp, currents, times, group.
// - Block sampled per cycle; blocked pick-up stops.
// - One pick-up drives both timers together.
// - Failure delay in 5 ms steps, default 200 ms.
`timescale 1ns/1ns
`include "bft_consts.vh"
module bft_breaker_failure_timer #(
  parameter TICK_CYCLES = `BFT_TICK_CYCLES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Supervision inputs
  input wire phase_over,
  input wire resid_over,
  input wire trip_monitor,
  input wire dig_in,
  input wire block_in,
  // Process data
  input wire [31:0] time_stamp,
  input wire [15:0] max_phase_current,
  input wire [15:0] residual_current,
  input wire [2:0] setting_group,
  // Protection outputs
  output reg breaker_failure_output,
  output reg repeat_trip_output,
  output reg unit_trip_output,
  output reg start_output,
  output reg blocked_output,
  // Event stream
  output reg failure_event_block_valid,
  output reg [2:0] failure_event_block_source,
  output reg failure_event_block_on,
  output reg [31:0] failure_event_block_stamp,
  output reg [15:0] failure_event_block_phase,
  output reg [15:0] failure_event_block_resid,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [19:0] FAIL_RST = `BFT_FAIL_STEPS;
  localparam [19:0] RETRIP_RST = `BFT_RETRIP_STEPS;

  reg [2:0] config_reg;
  reg [19:0] fail_delay;
  reg [19:0] retrip_delay;
  reg [15:0] event_sel;
  reg [3:0] log_sel;
  reg [31:0] tick_cnt;
  reg block_q;
  reg [19:0] fail_cnt;
  reg [19:0] rtr_cnt;
  reg [7:0] src_prev;
  reg [15:0] pend;
  reg [3:0] log_wp;
  reg [3:0] log_count;
  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg pick;
  reg armed;
  reg [2:0] cond;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg [3:0] gidx;
  reg gany;
  integer i;

  wire tick = (tick_cnt == TICK_CYCLES - 1);
  wire cur = phase_over | resid_over;
  wire [1:0] crit = config_reg[1:0];
  wire retrip_en = config_reg[`BFT_CFG_RETRIP_BIT];
  wire run = pick & ~block_q;
  wire fail_due = fail_cnt >= fail_delay;
  wire rtr_due = rtr_cnt >= retrip_delay;
  wire [19:0] ttf = fail_due ? 20'h0 : fail_delay - fail_cnt;
  wire [19:0] ttr = rtr_due ? 20'h0 : retrip_delay - rtr_cnt;
  wire [7:0] src_now = {resid_over, phase_over, dig_in, trip_monitor,
                        blocked_output, breaker_failure_output,
                        repeat_trip_output, start_output};
  wire [7:0] rise = src_now & ~src_prev;
  wire [7:0] fall = ~src_now & src_prev;
  wire [15:0] ev_set = {fall & event_sel[15:8], rise & event_sel[7:0]};
  wire [15:0] grant = gany ? (16'h1 << gidx) : 16'h0;
  wire log_we = gany & ~gidx[3] & ~gidx[2];
  wire [110:0] log_wdata = {setting_group, gidx, ttf, ttr,
                            residual_current, max_phase_current,
                            time_stamp};
  wire [3:0] log_raddr = (log_sel > `BFT_LOG_LAST) ? 4'h0 : log_sel;
  wire [110:0] log_rdata;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] w_masked = w_data & wmask;
  wire [7:0] wa = {aw_addr[7:2], 2'h0};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Exactly one criterion forms the shared pick-up.
  always @*
  begin
    case (crit)
      `BFT_CRIT_CUR: pick = cur;
      `BFT_CRIT_CUR_AND_OUT: pick = cur & trip_monitor;
      `BFT_CRIT_CUR_OR_OUT: pick = cur | trip_monitor;
      default: pick = dig_in;
    endcase
    // Overcurrent alone shows as a start while the timer stays halted.
    armed = (crit == `BFT_CRIT_CUR_AND_OUT) ? cur : pick;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt <= 32'h0;
      block_q <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      if (tick)
      begin
        block_q <= block_in;
      end
    end
  end

  // Both timers share one pick-up and clear together when it drops.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fail_cnt <= 20'h0;
      rtr_cnt <= 20'h0;
      breaker_failure_output <= 1'b0;
      repeat_trip_output <= 1'b0;
      unit_trip_output <= 1'b0;
      start_output <= 1'b0;
      blocked_output <= 1'b0;
    end
    else
    begin
      start_output <= armed & ~block_q;
      blocked_output <= armed & block_q;
      if (!run)
      begin
        fail_cnt <= 20'h0;
        rtr_cnt <= 20'h0;
        breaker_failure_output <= 1'b0;
        repeat_trip_output <= 1'b0;
        unit_trip_output <= 1'b0;
      end
      else
      begin
        if (tick && !fail_due)
        begin
          fail_cnt <= fail_cnt + 20'h1;
        end
        if (tick && !rtr_due)
        begin
          rtr_cnt <= rtr_cnt + 20'h1;
        end
        breaker_failure_output <= fail_due;
        repeat_trip_output <= retrip_en & rtr_due;
        unit_trip_output <= (crit == `BFT_CRIT_INPUT) & fail_due;
      end
    end
  end

  // Lowest pending event goes out first; others wait their turn.
  always @*
  begin
    gany = 1'b0;
    gidx = 4'h0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (pend[i])
      begin
        gany = 1'b1;
        gidx = i[3:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : pend_bit
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pend[g] <= 1'b0;
        end
        else
        begin
          // A new edge wins over the grant that clears the bit.
          pend[g] <= ev_set[g] | (pend[g] & ~grant[g]);
        end
      end
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_prev <= 8'h0;
      failure_event_block_valid <= 1'b0;
      failure_event_block_source <= 3'h0;
      failure_event_block_on <= 1'b0;
      failure_event_block_stamp <= 32'h0;
      failure_event_block_phase <= 16'h0;
      failure_event_block_resid <= 16'h0;
      log_wp <= 4'h0;
      log_count <= 4'h0;
    end
    else
    begin
      src_prev <= src_now;
      failure_event_block_valid <= gany;
      failure_event_block_source <= gidx[2:0];
      failure_event_block_on <= ~gidx[3];
      failure_event_block_stamp <= time_stamp;
      failure_event_block_phase <= max_phase_current;
      failure_event_block_resid <= residual_current;
      if (log_we)
      begin
        log_wp <= (log_wp == `BFT_LOG_LAST) ? 4'h0 : log_wp + 4'h1;
        if (log_count != `BFT_LOG_DEPTH)
        begin
          log_count <= log_count + 4'h1;
        end
      end
    end
  end

  bft_log_mem #(
    .W(`BFT_LOG_W),
    .D(`BFT_LOG_DEPTH),
    .A(`BFT_LOG_AW)
  ) u_log (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(log_we),
    .waddr(log_wp),
    .wdata(log_wdata),
    .raddr(log_raddr),
    .rdata(log_rdata)
  );

  // Address and data may arrive in either order.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h0;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BFT_RESP_OKAY;
      config_reg <= `BFT_CONFIG_RST;
      fail_delay <= FAIL_RST;
      retrip_delay <= RETRIP_RST;
      event_sel <= `BFT_EVENT_SEL_RST;
      log_sel <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `BFT_RESP_OKAY;
        case (wa)
          `BFT_REG_CONFIG:
            config_reg <= (config_reg & ~wmask[2:0]) | w_masked[2:0];
          `BFT_REG_FAIL_DELAY:
            fail_delay <= (fail_delay & ~wmask[19:0]) | w_masked[19:0];
          `BFT_REG_RETRIP_DELAY:
            retrip_delay <= (retrip_delay & ~wmask[19:0]) | w_masked[19:0];
          `BFT_REG_EVENT_SEL:
            event_sel <= (event_sel & ~wmask[15:0]) | w_masked[15:0];
          `BFT_REG_LOG_SEL:
            log_sel <= (log_sel & ~wmask[3:0]) | w_masked[3:0];
          `BFT_REG_STATUS, `BFT_REG_TIME_TO_FAIL, `BFT_REG_TIME_TO_RETRIP,
          `BFT_REG_LOG_STATE, `BFT_REG_LOG_STAMP, `BFT_REG_LOG_CURRENT,
          `BFT_REG_LOG_RETRIP, `BFT_REG_LOG_FAIL:
            s_axi_bresp <= `BFT_RESP_OKAY;
          default:
            s_axi_bresp <= `BFT_RESP_SLVERR;
        endcase
      end
    end
  end

  always @*
  begin
    if (blocked_output)
      cond = `BFT_COND_BLOCKED;
    else if (breaker_failure_output)
      cond = `BFT_COND_FAIL;
    else if (repeat_trip_output)
      cond = `BFT_COND_RETRIP;
    else if (start_output)
      cond = `BFT_COND_START;
    else
      cond = `BFT_COND_NORMAL;
  end

  always @*
  begin
    rd_ok = 1'b1;
    rd_mux = 32'h0;
    case (ra)
      `BFT_REG_CONFIG: rd_mux = {29'h0, config_reg};
      `BFT_REG_FAIL_DELAY: rd_mux = {12'h0, fail_delay};
      `BFT_REG_RETRIP_DELAY: rd_mux = {12'h0, retrip_delay};
      `BFT_REG_EVENT_SEL: rd_mux = {16'h0, event_sel};
      `BFT_REG_STATUS: rd_mux = {24'h0, unit_trip_output, block_q,
                                 run, cur, 1'b0, cond};
      `BFT_REG_TIME_TO_FAIL: rd_mux = {12'h0, ttf};
      `BFT_REG_TIME_TO_RETRIP: rd_mux = {12'h0, ttr};
      `BFT_REG_LOG_STATE: rd_mux = {24'h0, log_count, log_wp};
      `BFT_REG_LOG_SEL: rd_mux = {28'h0, log_sel};
      `BFT_REG_LOG_STAMP: rd_mux = log_rdata[31:0];
      `BFT_REG_LOG_CURRENT: rd_mux = log_rdata[63:32];
      `BFT_REG_LOG_RETRIP: rd_mux = {12'h0, log_rdata[83:64]};
      `BFT_REG_LOG_FAIL: rd_mux = {1'b0, log_rdata[110:104], 4'h0,
                                   log_rdata[103:84]};
      default: rd_ok = 1'b0;
    endcase
  end

  // Log data come from a registered read, so select the slot beforehand.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BFT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `BFT_RESP_OKAY : `BFT_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/bft_props.sv ----
// Purpose: Port checks of the breaker failure timer.
// Assumes: Bound to the top module; ON and OFF events of failure enabled.
// Notes: Only relations visible at the ports are watched here.
`timescale 1ns/1ns
module bft_props (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Supervision and process data
  input wire phase_over,
  input wire resid_over,
  input wire trip_monitor,
  input wire dig_in,
  input wire [31:0] time_stamp,
  input wire [15:0] max_phase_current,
  // Protection outputs
  input wire breaker_failure_output,
  input wire repeat_trip_output,
  input wire unit_trip_output,
  input wire start_output,
  input wire blocked_output,
  // Event stream
  input wire failure_event_block_valid,
  input wire [2:0] failure_event_block_source,
  input wire failure_event_block_on,
  input wire [31:0] failure_event_block_stamp,
  input wire [15:0] failure_event_block_phase,
  // Register bus
  input wire s_axi_awready,
  input wire s_axi_bvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire any_src = phase_over | resid_over | trip_monitor | dig_in;
  property p_fail_cause;
    breaker_failure_output |-> $past(any_src);
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("failure output without a live cause");
  property p_unit;
    unit_trip_output |-> breaker_failure_output;
  endproperty
  a_unit: assert property (p_unit)
    else $error("unit trip without failure output");
  property p_retrip_cause;
    repeat_trip_output |-> $past(any_src);
  endproperty
  a_retrip_cause: assert property (p_retrip_cause)
    else $error("repeat trip without a live cause");
  property p_fall_together;
    $fell(repeat_trip_output) |-> !breaker_failure_output;
  endproperty
  a_fall_together: assert property (p_fall_together)
    else $error("repeat trip dropped while failure held");
  property p_start_blk;
    !(start_output && blocked_output);
  endproperty
  a_start_blk: assert property (p_start_blk)
    else $error("start and blocked shown together");
  property p_ev_data;
    failure_event_block_valid |->
      failure_event_block_stamp == $past(time_stamp) &&
      failure_event_block_phase == $past(max_phase_current);
  endproperty
  a_ev_data: assert property (p_ev_data)
    else $error("event data not taken at the emitting edge");
  property p_fail_on;
    $rose(breaker_failure_output) |-> ##[0:20] (failure_event_block_valid
      && failure_event_block_source == 3'h2 && failure_event_block_on);
  endproperty
  a_fail_on: assert property (p_fail_on)
    else $error("no failure ON event");
  property p_fail_off;
    $fell(breaker_failure_output) |-> ##[0:20] (failure_event_block_valid
      && failure_event_block_source == 3'h2 && !failure_event_block_on);
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("no failure OFF event");
  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_aw_refuse: assert property (p_aw_refuse)
    else $error("write address accepted during a response");
endmodule
bind bft_breaker_failure_timer bft_props i_props (
  .aclk(aclk), .aresetn(aresetn), .phase_over(phase_over),
  .resid_over(resid_over), .trip_monitor(trip_monitor), .dig_in(dig_in),
  .time_stamp(time_stamp), .max_phase_current(max_phase_current),
  .breaker_failure_output(breaker_failure_output),
  .repeat_trip_output(repeat_trip_output),
  .unit_trip_output(unit_trip_output), .start_output(start_output),
  .blocked_output(blocked_output),
  .failure_event_block_valid(failure_event_block_valid),
  .failure_event_block_source(failure_event_block_source),
  .failure_event_block_on(failure_event_block_on),
  .failure_event_block_stamp(failure_event_block_stamp),
  .failure_event_block_phase(failure_event_block_phase),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid));

// ---- verification/bft_breaker_model.sv ----
// Purpose: Breaker and primary trip contact seen by the timer.
// Assumes: Fault levels and the trip command come from the bench.
// Notes: A healthy breaker opens LAG + 1 clocks after the trip command.
`timescale 1ns/1ns
module bft_breaker_model #(
  parameter LAG = 5
) (
  // Clock
  input wire aclk,
  // Commands from the bench
  input wire fault_ph,
  input wire fault_res,
  input wire trip_cmd,
  input wire healthy,
  // Comparator and contact levels
  output wire phase_over,
  output wire resid_over,
  output wire trip_monitor
);
  integer cnt = 0;
  reg brk_open = 1'b0;
  // The breaker stays open until the fault is gone, so a late drop of
  // the trip command cannot bring the current back.
  always @(posedge aclk)
  begin
    cnt <= (trip_cmd && healthy) ? cnt + 1 : 0;
    if (cnt >= LAG) brk_open <= 1'b1;
    else if (!fault_ph && !fault_res) brk_open <= 1'b0;
  end
  assign phase_over = fault_ph && !brk_open;
  assign resid_over = fault_res && !brk_open;
  assign trip_monitor = trip_cmd;
endmodule

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench of the breaker failure timer.
// Assumes: A program cycle of ten clocks through TICK_CYCLES.
// Notes: Case codes: [1:0] criterion, [2] cur, [3] trip, [4] input,
// [7:5] the same after the change, [8] healthy breaker, [9] block.
`timescale 1ns/1ns
`include "bft_consts.vh"
module testbench;
  localparam TICK = 10;
  localparam D = 4;
  localparam logic [9:0] TBL [10] = '{10'h004, 10'h048, 10'h065,
    10'h02D, 10'h04A, 10'h02E, 10'h013, 10'h007, 10'h12E, 10'h204};
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg f_ph = 1'b0, f_res = 1'b0, trip = 1'b0, hl = 1'b0;
  reg dig_in = 1'b0, block_in = 1'b0;
  reg [31:0] ts = 32'h0, wdata = 32'h0, rd_data;
  reg [15:0] mpc = 16'h0, rc = 16'h0;
  reg [2:0] sg = 3'h0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0;
  reg [1:0] rd_resp;
  reg [9:0] tc;
  wire ph_o, rs_o, tm, bfo, rto, uto, sto, blo;
  wire awready, wready, arready, bvalid, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_mismatch = 0, n_checks = 0, cyc = 0;
  integer i, r, cr, cu, p1, arm, a2, nlog = 0, lcode = 0;
  always #50 aclk = ~aclk;
  bft_breaker_model i_brk (.aclk(aclk), .fault_ph(f_ph), .fault_res(f_res),
    .trip_cmd(trip), .healthy(hl), .phase_over(ph_o), .resid_over(rs_o),
    .trip_monitor(tm));
  bft_breaker_failure_timer #(.TICK_CYCLES(TICK)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .phase_over(ph_o), .resid_over(rs_o),
    .trip_monitor(tm), .dig_in(dig_in), .block_in(block_in),
    .time_stamp(ts), .max_phase_current(mpc), .residual_current(rc),
    .setting_group(sg), .breaker_failure_output(bfo),
    .repeat_trip_output(rto), .unit_trip_output(uto), .start_output(sto),
    .blocked_output(blo), .failure_event_block_valid(),
    .failure_event_block_source(), .failure_event_block_on(),
    .failure_event_block_stamp(), .failure_event_block_phase(),
    .failure_event_block_resid(), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Process data moves every clock so stale captures show up.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    ts <= $urandom;
    mpc <= $urandom;
    rc <= $urandom;
    sg <= $urandom;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  function integer pk(input integer c, u, t, n);
    pk = c == 0 ? u : c == 1 ? u & t : c == 2 ? u | t : n;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input string name);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task axi_wr(input [7:0] a, input [31:0] d);
    reg aw_hit, w_hit;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(negedge aclk);
      while (awvalid || wvalid)
      begin
        aw_hit = awready;
        w_hit = wready;
        @(posedge aclk);
        if (aw_hit) awvalid <= 1'b0;
        if (w_hit) wvalid <= 1'b0;
        @(negedge aclk);
      end
      while (!bvalid) @(negedge aclk);
      @(posedge aclk);
      chk(bresp, `BFT_RESP_OKAY, "bresp");
      bready <= 1'b0;
    end
  endtask
  task axi_rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    @(posedge aclk);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task run_case(input [9:0] t);
    cr = t[1:0];
    r = $urandom % 3;
    hl <= t[8];
    block_in <= t[9];
    axi_wr(`BFT_REG_CONFIG, {29'h0, 1'b1, t[1:0]});
    repeat (12) @(posedge aclk);
    f_ph <= t[2] && r != 1;
    f_res <= t[2] && r != 0;
    trip <= t[3];
    dig_in <= t[4];
    cu = t[2] & ~(t[8] & t[3]);
    p1 = pk(cr, cu, t[3], t[4]) & ~t[9];
    arm = cr == 1 ? cu : pk(cr, cu, t[3], t[4]);
    repeat ((D - 1) * TICK) @(negedge aclk);
    chk(bfo, 0, "early fail");
    repeat (3 * TICK) @(negedge aclk);
    chk(bfo, p1, "fail");
    chk(rto, p1, "retrip");
    chk(uto, p1 & (cr == 3), "unit trip");
    chk(sto, arm & ~t[9], "start");
    chk(blo, arm & t[9], "blocked");
    axi_rd(`BFT_REG_STATUS);
    chk(rd_data[2:0], t[9] & arm ? 4 : p1 ? 3 : arm, "cond");
    @(posedge aclk);
    f_ph <= t[5] && r != 1;
    f_res <= t[5] && r != 0;
    trip <= t[6];
    dig_in <= t[7];
    cu = t[5] & ~(t[8] & (t[3] | t[6]));
    a2 = cr == 1 ? cu : pk(cr, cu, t[6], t[7]);
    // Start or blocked rises once in a case with arm or a2; retrip and failure with p1.
    nlog = nlog + (arm | a2) + 2 * p1;
    if (p1 || arm || a2) lcode = p1 ? 2 : t[9] ? 3 : 0;
    repeat (3) @(negedge aclk);
    chk(bfo, p1 & pk(cr, cu, t[6], t[7]), "fail later");
    @(posedge aclk);
    {f_ph, f_res, trip, dig_in, block_in} <= 5'h00;
    repeat (3 * TICK) @(posedge aclk);
    axi_rd(`BFT_REG_LOG_STATE);
    chk(rd_data, (nlog > `BFT_LOG_DEPTH ? `BFT_LOG_DEPTH : nlog) * 16
      + nlog % `BFT_LOG_DEPTH, "log state");
    axi_wr(`BFT_REG_LOG_SEL, (nlog + `BFT_LOG_DEPTH - 1) % `BFT_LOG_DEPTH);
    axi_rd(`BFT_REG_LOG_FAIL);
    chk(rd_data[27:20], lcode * 16, "log event");
  endtask
  initial
  begin
    rd_data = $urandom(32'h3043);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`BFT_REG_CONFIG);
    chk(rd_data, 32'h4, "config reset");
    axi_rd(`BFT_REG_FAIL_DELAY);
    chk(rd_data, 32'h28, "delay reset");
    axi_rd(8'hFC);
    chk(rd_resp, `BFT_RESP_SLVERR, "unmapped");
    axi_wr(`BFT_REG_FAIL_DELAY, D);
    axi_wr(`BFT_REG_RETRIP_DELAY, 32'h2);
    axi_rd(`BFT_REG_FAIL_DELAY);
    chk(rd_data, D, "delay");
    for (i = 0; i < 10; i = i + 1)
      run_case(TBL[i]);
    for (i = 0; i < 6; i = i + 1)
    begin
      tc = {2'b00, 8'($urandom)};
      run_case(tc);
    end
    tally_and_finish;
  end
endmodule
